// ===== core/fil_pkg.sv
// Behaviour
// - system event latch bit 7 sets on a clock error; offset 0x34
// - system event latch bit 6 sets when the PLL reports lock
// - system event latch bit 5 sets on boost over-temperature
// - system event latch bit 4 sets on boost over-current
// - system event latch bit 3 sets on the boost MO event
// - reserved bits read zero; host writes only zero to them
// - system event latch bits are read-only, self clearing, 1 means event
// - summary bit 7 at 0x35 shows faults in input channel 1
// - summary bit 6 shows faults in input channel 2
// - summary bit 5 shows faults in output channel 1
// - summary bit 4 shows faults in output channel 2
// - summary bit 3 shows short to battery while battery below bias
// - input one latch bit 7 at 0x36 sets on open inputs
// - input one latch bit 6 sets on inputs shorted together
// - bits 5 and 4 set on positive or negative input short to ground
// - bits 3 and 2 set on positive or negative input short to bias
// - bits 1 and 0 set on positive or negative input short to battery
// - input two latch at 0x37 uses the same self clearing layout
// - mask bit 1 blocks, 0 passes each fault summary to interrupt
`default_nettype none
package fil_pkg;

   // -----------------------------------------------------------------
   // register port
   // -----------------------------------------------------------------
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned DATA_W    = 8;

   localparam logic [7:0]  OFF_MASK  = 8'h30;
   localparam logic [7:0]  OFF_SYS   = 8'h34;
   localparam logic [7:0]  OFF_SUM   = 8'h35;
   localparam logic [7:0]  OFF_IN1   = 8'h36;
   localparam logic [7:0]  OFF_IN2   = 8'h37;

   localparam logic [7:0]  ZERO_BYTE = 8'h00;
   localparam logic [7:0]  MASK_RST  = 8'h08;
   localparam logic [7:0]  MASK_WR   = 8'hF8;

   // -----------------------------------------------------------------
   // system event latch fields
   // -----------------------------------------------------------------
   localparam int          SYS_N       = 5;
   localparam int          SYS_LSB     = 3;
   localparam int          SYS_MSB     = 7;
   localparam int          BIT_CLK_ERR = 7;
   localparam int          BIT_PLL_LCK = 6;
   localparam int          BIT_BST_OT  = 5;
   localparam int          BIT_BST_OC  = 4;
   localparam int          BIT_BST_MO  = 3;

   // -----------------------------------------------------------------
   // summary fields
   // -----------------------------------------------------------------
   localparam int          BIT_SUM_IN1  = 7;
   localparam int          BIT_SUM_IN2  = 6;
   localparam int          BIT_SUM_OUT1 = 5;
   localparam int          BIT_SUM_OUT2 = 4;
   localparam int          BIT_SUM_SBAT = 3;

   // -----------------------------------------------------------------
   // input channel latch fields
   // -----------------------------------------------------------------
   localparam int          BIT_OPEN     = 7;
   localparam int          BIT_SHORTED  = 6;
   localparam int          BIT_POS_GND  = 5;
   localparam int          BIT_NEG_GND  = 4;
   localparam int          BIT_POS_BIAS = 3;
   localparam int          BIT_NEG_BIAS = 2;
   localparam int          BIT_POS_BAT  = 1;
   localparam int          BIT_NEG_BAT  = 0;

endpackage
`default_nettype wire

// ===== core/fil_latch.sv
`timescale 1ns/1ps
`default_nettype none
module fil_latch
   import fil_pkg::*;
#(
   parameter int W = 8
)(
   input  wire logic         mclk,
   input  wire logic         srst,
   input  wire logic [W-1:0] set_in,
   input  wire logic         rd_clr,
   output logic      [W-1:0] q
);

   default clocking cb_mclk @(posedge mclk);
   endclocking

   // -----------------------------------------------------------------
   // sticky bits, set wins over read clear
   // -----------------------------------------------------------------
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   assign q_next = set_in | (q_reg & ~{W{rd_clr}});
   assign q      = q_reg;

   always_ff @(posedge mclk) begin
      if (srst) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   a_set_wins: assert property (@(posedge mclk) disable iff (srst)
      (set_in != '0) |=> ((q_reg & $past(set_in)) == $past(set_in)))
      else $error("latched event lost");

   a_hold_clear: assert property (disable iff (srst)
      (!rd_clr && set_in == '0) |=> (q_reg == $past(q_reg)))
      else $error("latch changed without read or event");

endmodule
`default_nettype wire

// ===== core/fil_top.sv
`timescale 1ns/1ps
`default_nettype none
module fil_top
   import fil_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              srst,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic              reg_wr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   output logic                   reg_rvalid,
   // system events
   input  wire logic              clk_err_evt,
   input  wire logic              pll_lock_evt,
   input  wire logic              boost_ot_evt,
   input  wire logic              boost_oc_evt,
   input  wire logic              boost_mo_evt,
   // channel faults
   input  wire logic [7:0]        in_one_fault,
   input  wire logic [7:0]        in_two_fault,
   input  wire logic              out_one_fault,
   input  wire logic              out_two_fault,
   input  wire logic              short_bat_low_evt,
   // interrupt request
   output logic                   fault_irq
);

   default clocking cb_mclk @(posedge mclk);
   endclocking

   // -----------------------------------------------------------------
   // address decode
   // -----------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   logic rd_sys;
   logic rd_sum;
   logic rd_in1;
   logic rd_in2;
   logic rd_mask;
   logic wr_mask;

   assign rd_sys  = reg_rd & hit(reg_addr, OFF_SYS);
   assign rd_sum  = reg_rd & hit(reg_addr, OFF_SUM);
   assign rd_in1  = reg_rd & hit(reg_addr, OFF_IN1);
   assign rd_in2  = reg_rd & hit(reg_addr, OFF_IN2);
   assign rd_mask = reg_rd & hit(reg_addr, OFF_MASK);
   assign wr_mask = reg_wr & hit(reg_addr, OFF_MASK);

   // -----------------------------------------------------------------
   // system event latch
   // -----------------------------------------------------------------
   logic [SYS_N-1:0] sys_set;
   logic [SYS_N-1:0] sys_q;
   logic [7:0]       sys_view;

   assign sys_set = {clk_err_evt,
                     pll_lock_evt,
                     boost_ot_evt,
                     boost_oc_evt,
                     boost_mo_evt};

   fil_latch #(
      .W      (SYS_N)
   ) u_sys (
      .mclk   (mclk),
      .srst   (srst),
      .set_in (sys_set),
      .rd_clr (rd_sys),
      .q      (sys_q)
   );

   assign sys_view[SYS_MSB:SYS_LSB] = sys_q;
   assign sys_view[SYS_LSB-1:0]     = ZERO_BYTE[SYS_LSB-1:0];

   // -----------------------------------------------------------------
   // input channel latches
   // -----------------------------------------------------------------
   logic [7:0] in1_q;
   logic [7:0] in2_q;

   fil_latch #(
      .W      (DATA_W)
   ) u_in1 (
      .mclk   (mclk),
      .srst   (srst),
      .set_in (in_one_fault),
      .rd_clr (rd_in1),
      .q      (in1_q)
   );

   fil_latch #(
      .W      (DATA_W)
   ) u_in2 (
      .mclk   (mclk),
      .srst   (srst),
      .set_in (in_two_fault),
      .rd_clr (rd_in2),
      .q      (in2_q)
   );

   // -----------------------------------------------------------------
   // short to battery while battery below bias
   // -----------------------------------------------------------------
   logic sbat_q;

   fil_latch #(
      .W      (1)
   ) u_sbat (
      .mclk   (mclk),
      .srst   (srst),
      .set_in (short_bat_low_evt),
      .rd_clr (rd_sum),
      .q      (sbat_q)
   );

   // -----------------------------------------------------------------
   // channel fault summary
   // -----------------------------------------------------------------
   logic [7:0] sum_view;

   assign sum_view[BIT_SUM_IN1]  = |in1_q;
   assign sum_view[BIT_SUM_IN2]  = |in2_q;
   assign sum_view[BIT_SUM_OUT1] = out_one_fault;
   assign sum_view[BIT_SUM_OUT2] = out_two_fault;
   assign sum_view[BIT_SUM_SBAT] = sbat_q;
   assign sum_view[SYS_LSB-1:0]  = ZERO_BYTE[SYS_LSB-1:0];

   // -----------------------------------------------------------------
   // interrupt mask
   // -----------------------------------------------------------------
   logic [7:0] mask_reg;
   logic [7:0] mask_next;

   assign mask_next = wr_mask ? (reg_wdata & MASK_WR) : mask_reg;

   always_ff @(posedge mclk) begin
      if (srst) begin
         mask_reg <= MASK_RST;
      end else begin
         mask_reg <= mask_next;
      end
   end

   // -----------------------------------------------------------------
   // interrupt output
   // -----------------------------------------------------------------
   logic irq_reg;
   logic irq_next;

   assign irq_next = |(sum_view & ~mask_reg);

   always_ff @(posedge mclk) begin
      if (srst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   assign fault_irq = irq_reg;

   // -----------------------------------------------------------------
   // read data path
   // -----------------------------------------------------------------
   logic [7:0] rd_mux;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       rvalid_reg;

   assign rd_mux = rd_sys  ? sys_view :
                   rd_sum  ? sum_view :
                   rd_in1  ? in1_q    :
                   rd_in2  ? in2_q    :
                   rd_mask ? mask_reg : ZERO_BYTE;

   assign rdata_next = reg_rd ? rd_mux : rdata_reg;

   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata_reg  <= ZERO_BYTE;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= reg_rd;
      end
   end

   assign reg_rdata  = rdata_reg;
   assign reg_rvalid = rvalid_reg;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_clk_err_set: assert property (disable iff (srst)
      clk_err_evt |=> sys_view[BIT_CLK_ERR])
      else $error("clock error not latched");

   a_pll_lock_set: assert property (disable iff (srst)
      pll_lock_evt |=> sys_view[BIT_PLL_LCK])
      else $error("pll lock not latched");

   a_boost_ot_set: assert property (disable iff (srst)
      boost_ot_evt |=> sys_view[BIT_BST_OT])
      else $error("boost over temperature not latched");

   a_boost_oc_set: assert property (disable iff (srst)
      boost_oc_evt |=> sys_view[BIT_BST_OC])
      else $error("boost over current not latched");

   a_boost_mo_set: assert property (disable iff (srst)
      boost_mo_evt |=> sys_view[BIT_BST_MO])
      else $error("boost mo event not latched");

   a_rsvd_zero: assert property (disable iff (srst)
      ($past(rd_sys) || $past(rd_sum) || $past(rd_mask)) && reg_rvalid
      |-> reg_rdata[SYS_LSB-1:0] == ZERO_BYTE[SYS_LSB-1:0])
      else $error("reserved bits read non zero");

   a_sys_readout: assert property (disable iff (srst)
      rd_sys ##1 reg_rvalid |-> reg_rdata == $past(sys_view))
      else $error("system latch readback wrong");

   a_sys_clear: assert property (disable iff (srst)
      (rd_sys && sys_set == '0)
      |=> (sys_q == '0) ##1 (sys_q == '0 || $past(sys_set) != '0))
      else $error("system latch not cleared by read");

   a_sum_in1: assert property (@(posedge mclk) disable iff (srst)
      in_one_fault[BIT_OPEN] |=> sum_view[BIT_SUM_IN1] && in1_q[BIT_OPEN])
      else $error("input one summary missing");

   a_sum_in2: assert property (@(posedge mclk) disable iff (srst)
      in_two_fault[BIT_NEG_BAT]
      |=> sum_view[BIT_SUM_IN2] && in2_q[BIT_NEG_BAT])
      else $error("input two summary missing");

   a_sum_out: assert property (@(posedge mclk) disable iff (srst)
      reg_rd && hit(reg_addr, OFF_SUM)
      |=> reg_rdata[BIT_SUM_OUT1] == $past(out_one_fault)
       && reg_rdata[BIT_SUM_OUT2] == $past(out_two_fault))
      else $error("output channel summary wrong");

   a_sbat_hold: assert property (disable iff (srst)
      short_bat_low_evt ##1 !rd_sum |=> sum_view[BIT_SUM_SBAT])
      else $error("short to battery summary dropped");

   a_in1_bits: assert property (@(posedge mclk) disable iff (srst)
      (in_one_fault[BIT_POS_GND] && in_one_fault[BIT_NEG_BIAS])
      |=> in1_q[BIT_POS_GND] && in1_q[BIT_NEG_BIAS])
      else $error("input one fault bit not latched");

   a_in1_short: assert property (disable iff (srst)
      in_one_fault[BIT_SHORTED] ##1 !rd_in1 |-> in1_q[BIT_SHORTED] [*2])
      else $error("inputs shorted latch not held");

   a_in1_bat: assert property (@(posedge mclk) disable iff (srst)
      in_one_fault[BIT_POS_BAT] && rd_in1 |=> in1_q[BIT_POS_BAT])
      else $error("battery short lost on read");

   a_in2_clear: assert property (disable iff (srst)
      rd_in2 && in_two_fault == ZERO_BYTE |=> in2_q == ZERO_BYTE)
      else $error("input two latch not cleared by read");

   a_in1_readout: assert property (disable iff (srst)
      rd_in1 |=> reg_rvalid && reg_rdata == $past(in1_q))
      else $error("input one readback wrong");

   a_irq_mask: assert property (@(posedge mclk) disable iff (srst)
      (sum_view & ~mask_reg) == ZERO_BYTE |=> !fault_irq)
      else $error("masked fault raised interrupt");

   a_irq_pass: assert property (@(posedge mclk) disable iff (srst)
      sum_view[BIT_SUM_IN1] && !mask_reg[BIT_SUM_IN1] |=> fault_irq)
      else $error("unmasked fault missed interrupt");

   a_sum_or: assert property (disable iff (srst)
      rd_sum |=> reg_rdata[BIT_SUM_IN2] == ($past(in2_q) != ZERO_BYTE)
       && reg_rdata[BIT_SUM_IN1] == ($past(in1_q) != ZERO_BYTE))
      else $error("summary not or of latch");

   a_wr_ignored: assert property (disable iff (srst)
      reg_wr && hit(reg_addr, OFF_IN1) && !reg_rd
       && in_one_fault == ZERO_BYTE
      |=> in1_q == $past(in1_q))
      else $error("write changed input one latch");

   a_reset_zero: assert property (@(posedge mclk)
      srst |=> sys_q == '0 && in1_q == ZERO_BYTE && in2_q == ZERO_BYTE
       && !sbat_q && mask_reg == MASK_RST && !fault_irq && !reg_rvalid)
      else $error("reset state wrong");

   a_unmapped: assert property (@(posedge mclk) disable iff (srst)
      reg_rd && !rd_sys && !rd_sum && !rd_in1 && !rd_in2 && !rd_mask
      |=> reg_rdata == ZERO_BYTE)
      else $error("unmapped read non zero");

endmodule
`default_nettype wire

// ===== tb/fil_host.sv
`timescale 1ns/1ps
`default_nettype none
module fil_host
   import fil_pkg::*;
(
   input  wire logic              mclk,
   output logic      [ADDR_W-1:0] reg_addr,
   output logic                   reg_wr,
   output logic      [DATA_W-1:0] reg_wdata,
   output logic                   reg_rd,
   input  wire logic [DATA_W-1:0] reg_rdata,
   input  wire logic              reg_rvalid
);
   // ---------------------------------------------------------------
   // idle port
   // ---------------------------------------------------------------
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      reg_rd    = 1'b0;
   end

   // ---------------------------------------------------------------
   // write: one strobe cycle, then lines scrambled
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= (a == OFF_MASK) ? (d & MASK_WR) : ZERO_BYTE;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask

   // ---------------------------------------------------------------
   // read: one strobe cycle, bounded wait for the answer
   // ---------------------------------------------------------------
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic ok);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      ok = 1'b0;
      d  = 8'h00;
      for (int n = 0; n < 4 && !ok; n++) begin
         #1;
         if (reg_rvalid === 1'b1) begin
            ok = 1'b1;
            d  = reg_rdata;
         end else begin
            @(posedge mclk);
         end
      end
   endtask
endmodule
`default_nettype wire

// ===== tb/fault_interrupt_latches_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fault_interrupt_latches_tb
   import fil_pkg::*;
;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic [23:0] ev   = 24'h000000;
   logic        rnd_on = 1'b0;
   logic [31:0] seed = 32'h9CB3DB01;
   wire  [7:0]  reg_addr;
   wire  [7:0]  reg_wdata;
   wire  [7:0]  reg_rdata;
   wire         reg_wr;
   wire         reg_rd;
   wire         reg_rvalid;
   wire         fault_irq;
   int          n_mismatch = 0;
   int          checks = 0;
   logic [7:0]  sys_m, in1_m, in2_m, mask_m, exp_rd;
   logic        sbat_m, exp_irq, exp_rv;
   logic [7:0]  tbl [6] = '{OFF_MASK, OFF_SYS, OFF_SUM, OFF_IN1, OFF_IN2,
                            8'h3A};

   always #4 mclk = ~mclk;

   fil_top u_fil_top (
      .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .clk_err_evt(ev[23]),
      .pll_lock_evt(ev[22]), .boost_ot_evt(ev[21]),
      .boost_oc_evt(ev[20]), .boost_mo_evt(ev[19]),
      .in_one_fault(ev[18:11]), .in_two_fault(ev[10:3]),
      .out_one_fault(ev[2]), .out_two_fault(ev[1]),
      .short_bat_low_evt(ev[0]), .fault_irq(fault_irq));

   fil_host u_fil_host (
      .mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction

   function automatic logic [7:0] sum_v();
      return {|in1_m, |in2_m, ev[2], ev[1], sbat_m, 3'b000};
   endfunction

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic rd_chk(input logic [7:0] a);
      logic [7:0] d;
      logic       ok;
      u_fil_host.rd(a, d, ok);
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("MISMATCH reg_rvalid expected 1 seen 0");
         complete_run();
      end else begin
         check("reg_rdata", d, exp_rd);
      end
   endtask

   // ---------------------------------------------------------------
   // reference model, updated at every rising edge
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      exp_irq = |(sum_v() & ~mask_m);
      if (reg_rd) begin
         case (reg_addr)
            OFF_MASK: exp_rd = mask_m;
            OFF_SYS:  exp_rd = sys_m;
            OFF_SUM:  exp_rd = sum_v();
            OFF_IN1:  exp_rd = in1_m;
            OFF_IN2:  exp_rd = in2_m;
            default:  exp_rd = ZERO_BYTE;
         endcase
      end
      sys_m  = ((reg_rd && reg_addr == OFF_SYS) ? ZERO_BYTE : sys_m)
               | {ev[23:19], 3'b000};
      in1_m  = ((reg_rd && reg_addr == OFF_IN1) ? ZERO_BYTE : in1_m)
               | ev[18:11];
      in2_m  = ((reg_rd && reg_addr == OFF_IN2) ? ZERO_BYTE : in2_m)
               | ev[10:3];
      sbat_m = ((reg_rd && reg_addr == OFF_SUM) ? 1'b0 : sbat_m) | ev[0];
      if (reg_wr && reg_addr == OFF_MASK) begin
         mask_m = reg_wdata & MASK_WR;
      end
      exp_rv = reg_rd && !srst;
      if (srst) begin
         {sys_m, in1_m, in2_m, sbat_m, exp_irq} = '0;
         mask_m = MASK_RST;
      end
      #1;
      check("fault_irq", {7'h00, fault_irq}, {7'h00, exp_irq});
      check("reg_rvalid", {7'h00, reg_rvalid}, {7'h00, exp_rv});
   end

   // ---------------------------------------------------------------
   // sparse random events
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      if (rnd_on) begin
         seed = lfsr(seed);
         ev <= seed[23:0] & seed[31:8] & {seed[7:0], seed[31:16]};
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      foreach (tbl[i]) rd_chk(tbl[i]);
      u_fil_host.wr(OFF_MASK, 8'h00);
      for (int i = 0; i < 24; i++) begin
         @(posedge mclk);
         ev <= 24'h000001 << i;
         @(posedge mclk);
         ev <= 24'h000000;
         u_fil_host.wr(tbl[1 + i % 5], 8'hFF);
         repeat (2) foreach (tbl[j]) rd_chk(tbl[j]);
      end
      @(posedge mclk);
      ev <= 24'h800801;
      repeat (2) foreach (tbl[j]) rd_chk(tbl[j]);
      @(posedge mclk);
      ev <= 24'h000000;
      repeat (2) foreach (tbl[j]) rd_chk(tbl[j]);
      rnd_on = 1'b1;
      repeat (400) begin
         seed = lfsr(seed);
         if (seed[2:0] == 3'd0) begin
            u_fil_host.wr(OFF_MASK, seed[15:8]);
         end else if (seed[2:0] == 3'd1) begin
            u_fil_host.wr(tbl[seed[10:8] % 6], seed[23:16]);
         end else begin
            rd_chk(tbl[seed[10:8] % 6]);
         end
      end
      rnd_on = 1'b0;
      @(posedge mclk);
      ev   <= 24'h000000;
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      foreach (tbl[i]) rd_chk(tbl[i]);
      complete_run();
   end
endmodule
`default_nettype wire
